// file: core/bms_defines.svh
// constants for the bridge measurement sequencer
`ifndef BMS_DEFINES_SVH
`define BMS_DEFINES_SVH

// ----------------------------------------------------------------
// nonvolatile word indices
// ----------------------------------------------------------------
`define BMS_NV_SETUP  3'h0
`define BMS_NV_SPAN   3'h1
`define BMS_NV_OFFS   3'h2
`define BMS_NV_TC1    3'h3
`define BMS_NV_TC2    3'h4

// ----------------------------------------------------------------
// setup word fields and reset values
// ----------------------------------------------------------------
`define BMS_G1_LO     0
`define BMS_G2_LO     2
`define BMS_MSB_LO    6
`define BMS_LSB_LO    8
`define BMS_POL_BIT   11
`define BMS_SETUP_RST 16'h0000
`define BMS_SPAN_RST  16'h8000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BMS_CLK_MHZ        50
`define BMS_ADC_CLK_MHZ    1
`define BMS_T_PROG_MIN_US  500
`define BMS_T_PROG_MAX_US  600
`define BMS_T_WUP1_MS      0.5
`define BMS_T_WUP2_MS      2.0
`define BMS_T_STA1_MS      1.0
`define BMS_T_STA2_MS      2.5
`define BMS_LINK_MAX_MHZ   20

`endif

// file: core/bms_pkg.sv
// types shared by both ends of the sequencer link
package bms_pkg;

  typedef enum logic [3:0] {
    CMD_NOP       = 4'h0,
    CMD_MEAS_FULL = 4'h1,
    CMD_MEAS_BR   = 4'h2,
    CMD_MEAS_TM   = 4'h3,
    CMD_MEAS_OFF  = 4'h4,
    CMD_NV_WRITE  = 4'h5,
    CMD_NV_READ   = 4'h6,
    CMD_MODE_AUTO = 4'h7,
    CMD_MODE_CMD  = 4'h8,
    CMD_SLEEP     = 4'h9,
    CMD_WAKE      = 4'hA
  } bms_cmd_t;

  typedef enum logic [1:0] {
    SEL_BRIDGE = 2'h0,
    SEL_TEMP   = 2'h1,
    SEL_SHORT  = 2'h2
  } bms_sel_t;

  typedef enum logic [3:0] {
    ST_PWRUP  = 4'h0,
    ST_SLEEP  = 4'h1,
    ST_WAKE   = 4'h2,
    ST_IDLE   = 4'h3,
    ST_AZ     = 4'h4,
    ST_CONV   = 4'h5,
    ST_CORR   = 4'h6,
    ST_REPORT = 4'h7,
    ST_PROG   = 4'h8
  } bms_state_t;

  typedef enum logic [1:0] {
    H_BOOT = 2'h0,
    H_IDLE = 2'h1,
    H_SEND = 2'h2,
    H_HOLD = 2'h3
  } bms_hstate_t;

endpackage : bms_pkg

// file: core/bms_link_if.sv
// link between host controller and sequencer
`timescale 1ns/1ns
interface bms_link_if;
  import bms_pkg::*;
  logic        cmd_valid;
  bms_cmd_t    cmd_code;
  logic [2:0]  cmd_addr;
  logic [15:0] cmd_data;
  logic        cmd_ack;
  logic        host_wake;
  logic        dev_ready;
  logic        dev_busy;
  logic        rsp_valid;
  logic [15:0] rsp_data;

  modport dev (
    input  cmd_valid, cmd_code, cmd_addr, cmd_data, host_wake,
    output cmd_ack, dev_ready, dev_busy, rsp_valid, rsp_data
  );
  modport hst (
    output cmd_valid, cmd_code, cmd_addr, cmd_data, host_wake,
    input  cmd_ack, dev_ready, dev_busy, rsp_valid, rsp_data
  );
endinterface : bms_link_if

// file: core/bms_timer.sv
// one-shot down counter with done pulse
`timescale 1ns/1ns
module bms_timer #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= value;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_q <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule : bms_timer

// file: core/bms_device.sv
// measurement sequencer, device end of the link
`timescale 1ns/1ns
`include "bms_defines.svh"
module bms_device import bms_pkg::*; #(
  parameter int STA1_CYC = int'(`BMS_T_STA1_MS * 1000.0 * `BMS_CLK_MHZ),
  parameter int STA2_CYC = int'(`BMS_T_STA2_MS * 1000.0 * `BMS_CLK_MHZ),
  parameter int WUP1_CYC = int'(`BMS_T_WUP1_MS * 1000.0 * `BMS_CLK_MHZ),
  parameter int WUP2_CYC = int'(`BMS_T_WUP2_MS * 1000.0 * `BMS_CLK_MHZ),
  parameter int PROG_CYC = `BMS_T_PROG_MIN_US * `BMS_CLK_MHZ,
  parameter int ADC_DIV  = `BMS_CLK_MHZ / `BMS_ADC_CLK_MHZ
) (
  input  wire logic  clk,
  input  wire logic  arst_n,
  input  wire logic  clk_en,
  input  wire logic  supply_ok,
  input  wire logic  wake_tick,
  bms_link_if.dev    link,
  output bms_sel_t   afe_sel,
  output logic       afe_autozero,
  output logic       afe_converting,
  output logic       afe_chop_inv,
  output logic [5:0] afe_gain1,
  output logic [4:0] afe_gain2_x10,
  output logic [4:0] afe_msb_bits,
  output logic [2:0] afe_lsb_bits,
  input  wire logic [15:0] adc_result,
  output logic       sleeping,
  output logic       analog_ready
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  bms_state_t  state_q;
  bms_sel_t    meas_q;
  logic        full_q, auto_q, word_q, por_q, tmr_load_q;
  logic [16:0] up_cnt_q;
  logic [15:0] nv_q [`BMS_NV_SETUP:`BMS_NV_TC2];
  logic [15:0] az_br_q, az_tm_q, raw_br_q, raw_tm_q, raw_off_q;
  logic [15:0] res0_q, res1_q, rsp_data_q;
  logic        rsp_valid_q;
  logic        tmr_done, link_ready, accept, start_w;
  logic [23:0] conv_cyc, tmr_val;
  logic [16:0] lim1, lim2;

  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v < 18'sh00000)
      sat16 = 16'h0000;
    else if (v > 18'sh0FFFF)
      sat16 = 16'hFFFF;
    else
      sat16 = v[15:0];
  endfunction : sat16

  // --------------------------------------------------------------
  // ready timing after power-up or wake
  // --------------------------------------------------------------
  // power-up limits while por_q is set, wake limits otherwise
  assign lim1 = por_q ? 17'(STA1_CYC) : 17'(WUP1_CYC);
  assign lim2 = por_q ? 17'(STA2_CYC) : 17'(WUP2_CYC);
  assign link_ready   = (state_q != ST_SLEEP) && (up_cnt_q >= lim1);
  assign analog_ready = (state_q != ST_SLEEP) && (up_cnt_q >= lim2);
  assign sleeping     = (state_q == ST_SLEEP);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_cnt_q <= 17'h00000;
      por_q    <= 1'b1;
    end else if (clk_en && !supply_ok) begin
      up_cnt_q <= 17'h00000;
      por_q    <= 1'b1;
    end else if (clk_en) begin
      if (state_q == ST_SLEEP) begin
        up_cnt_q <= 17'h00000;
        por_q    <= 1'b0;
      end else if (up_cnt_q < lim2) begin
        up_cnt_q <= up_cnt_q + 17'h00001;
      end
    end
  end

  // --------------------------------------------------------------
  // link handshake
  // --------------------------------------------------------------
  assign accept          = link.cmd_valid && (state_q == ST_IDLE);
  assign link.cmd_ack    = accept;
  assign link.dev_ready  = link_ready;
  assign link.dev_busy   = (state_q != ST_IDLE);
  assign link.rsp_valid  = rsp_valid_q;
  assign link.rsp_data   = rsp_data_q;

  assign start_w = (((state_q == ST_PWRUP) || (state_q == ST_WAKE))
                    && analog_ready && auto_q)
                || (accept && (link.cmd_code inside {CMD_MEAS_FULL,
                    CMD_MEAS_BR, CMD_MEAS_TM, CMD_MEAS_OFF}));

  // --------------------------------------------------------------
  // nonvolatile store
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i <= 4; i++) nv_q[i] <= 16'h0000;
      nv_q[`BMS_NV_SETUP] <= `BMS_SETUP_RST;
      nv_q[`BMS_NV_SPAN]  <= `BMS_SPAN_RST;
    end else if (clk_en && accept && link.cmd_code == CMD_NV_WRITE
                 && link.cmd_addr <= `BMS_NV_TC2) begin
      nv_q[link.cmd_addr] <= link.cmd_data;
    end
  end

  // --------------------------------------------------------------
  // analog controls, settings latched at measurement start, afe_sel from meas_q, phase flags from state
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      afe_gain1     <= 6'h0C;
      afe_gain2_x10 <= 5'h0B;
      afe_chop_inv  <= 1'b0;
      afe_msb_bits  <= 5'h0A;
      afe_lsb_bits  <= 3'h0;
    end else if (clk_en && start_w) begin
      unique case (nv_q[`BMS_NV_SETUP][`BMS_G1_LO +: 2])
        2'h0: afe_gain1 <= 6'h0C;
        2'h1: afe_gain1 <= 6'h14;
        2'h2: afe_gain1 <= 6'h1E;
        2'h3: afe_gain1 <= 6'h28;
      endcase
      afe_gain2_x10 <= 5'h0B + {2'h0, nv_q[`BMS_NV_SETUP][`BMS_G2_LO +: 3]};
      afe_chop_inv  <= nv_q[`BMS_NV_SETUP][`BMS_POL_BIT];
      afe_msb_bits  <= 5'h0A
                     + {2'h0, nv_q[`BMS_NV_SETUP][`BMS_MSB_LO +: 2], 1'b0};
      afe_lsb_bits  <= (nv_q[`BMS_NV_SETUP][`BMS_LSB_LO +: 2] == 2'h3)
                     ? 3'h7 : {nv_q[`BMS_NV_SETUP][`BMS_LSB_LO +: 2], 1'b0};
    end
  end

  assign afe_sel        = meas_q;
  assign afe_autozero   = (state_q == ST_AZ);
  assign afe_converting = (state_q == ST_AZ) || (state_q == ST_CONV);

  // --------------------------------------------------------------
  // conversion and programming timer
  // --------------------------------------------------------------
  // time follows resolution
  assign conv_cyc = 24'((25'h1 << afe_msb_bits) + (25'h1 << afe_lsb_bits))
                  * 24'(ADC_DIV);
  assign tmr_val  = (state_q == ST_PROG) ? 24'(PROG_CYC) : conv_cyc;

  bms_timer #(.W(24)) u_tmr (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .load   (tmr_load_q),
    .value  (tmr_val),
    .busy   (),
    .done   (tmr_done)
  );

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_PWRUP;
      meas_q     <= SEL_BRIDGE;
      full_q     <= 1'b0;
      auto_q     <= 1'b0;
      word_q     <= 1'b0;
      tmr_load_q <= 1'b0;
    end else if (clk_en && !supply_ok) begin
      state_q    <= ST_PWRUP;
      tmr_load_q <= 1'b0;
    end else if (clk_en) begin
      tmr_load_q <= 1'b0;
      unique case (state_q)
        ST_PWRUP, ST_WAKE: if (analog_ready) begin
          if (auto_q) begin
            full_q     <= 1'b1;
            meas_q     <= SEL_BRIDGE;
            state_q    <= ST_AZ;
            tmr_load_q <= 1'b1;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_SLEEP: if (link.host_wake || (auto_q && wake_tick))
          state_q <= ST_WAKE;
        ST_IDLE: if (accept) begin
          word_q <= 1'b0;
          full_q <= 1'b0;
          case (link.cmd_code)
            CMD_MEAS_FULL: begin
              full_q <= 1'b1;
              meas_q <= SEL_BRIDGE;
              state_q <= ST_AZ;
              tmr_load_q <= 1'b1;
            end
            CMD_MEAS_BR, CMD_MEAS_TM: begin
              meas_q <= (link.cmd_code == CMD_MEAS_BR) ? SEL_BRIDGE
                                                       : SEL_TEMP;
              state_q <= ST_AZ;
              tmr_load_q <= 1'b1;
            end
            CMD_MEAS_OFF: begin
              meas_q <= SEL_SHORT;
              state_q <= ST_CONV;
              tmr_load_q <= 1'b1;
            end
            CMD_NV_WRITE: begin
              state_q <= ST_PROG;
              tmr_load_q <= 1'b1;
            end
            CMD_NV_READ: state_q <= ST_REPORT;
            CMD_MODE_AUTO: begin
              auto_q <= 1'b1;
              state_q <= ST_SLEEP;
            end
            CMD_MODE_CMD: auto_q <= 1'b0;
            CMD_SLEEP: state_q <= ST_SLEEP;
            default: ;
          endcase
        end
        ST_AZ: if (tmr_done) begin
          state_q    <= ST_CONV;
          tmr_load_q <= 1'b1;
        end
        ST_CONV: if (tmr_done) begin
          if (full_q && meas_q == SEL_BRIDGE) begin
            meas_q     <= SEL_TEMP;
            state_q    <= ST_AZ;
            tmr_load_q <= 1'b1;
          end else if (full_q && meas_q == SEL_TEMP) begin
            meas_q     <= SEL_SHORT;
            state_q    <= ST_CONV;
            tmr_load_q <= 1'b1;
          end else begin
            state_q <= ST_CORR;
          end
        end
        ST_CORR: begin
          word_q  <= 1'b0;
          state_q <= ST_REPORT;
        end
        ST_REPORT: begin
          word_q <= 1'b1;
          if (!full_q || word_q)
            state_q <= auto_q ? ST_SLEEP : ST_IDLE;
        end
        ST_PROG: if (tmr_done) state_q <= ST_IDLE;
        default: state_q <= ST_PWRUP;
      endcase
    end
  end

  // --------------------------------------------------------------
  // sample capture
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      az_br_q   <= 16'h0000;
      az_tm_q   <= 16'h0000;
      raw_br_q  <= 16'h0000;
      raw_tm_q  <= 16'h0000;
      raw_off_q <= 16'h0000;
    end else if (clk_en && tmr_done) begin
      if (state_q == ST_AZ && meas_q == SEL_BRIDGE) az_br_q <= adc_result;
      if (state_q == ST_AZ && meas_q == SEL_TEMP)   az_tm_q <= adc_result;
      if (state_q == ST_CONV) begin
        unique case (meas_q)
          SEL_BRIDGE: raw_br_q  <= adc_result;
          SEL_TEMP:   raw_tm_q  <= adc_result;
          SEL_SHORT:  raw_off_q <= adc_result;
          default: ;
        endcase
      end
    end
  end

  // --------------------------------------------------------------
  // correction arithmetic
  // --------------------------------------------------------------
  logic signed [17:0] d_br, d_tm, t_sq, sum;
  logic signed [35:0] p_span, p_t1, p_sq, p_t2;

  always_comb begin
    d_br   = $signed({2'h0, raw_br_q}) - $signed({2'h0, az_br_q});
    d_tm   = $signed({2'h0, raw_tm_q}) - $signed({2'h0, az_tm_q});
    p_span = d_br * $signed({2'h0, nv_q[`BMS_NV_SPAN]});
    p_t1   = d_tm * $signed({{2{nv_q[`BMS_NV_TC1][15]}}, nv_q[`BMS_NV_TC1]});
    p_sq   = d_tm * d_tm;
    t_sq   = $signed(p_sq[33:16]);
    p_t2   = t_sq * $signed({{2{nv_q[`BMS_NV_TC2][15]}}, nv_q[`BMS_NV_TC2]});
    sum    = $signed(p_span[32:15])
           + $signed({{2{nv_q[`BMS_NV_OFFS][15]}}, nv_q[`BMS_NV_OFFS]})
           + $signed(p_t1[33:16]) + $signed(p_t2[33:16]);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res0_q <= 16'h0000;
      res1_q <= 16'h0000;
    end else if (clk_en && accept && link.cmd_code == CMD_NV_READ) begin
      res0_q <= (link.cmd_addr <= `BMS_NV_TC2) ? nv_q[link.cmd_addr]
                                               : 16'h0000;
    end else if (clk_en && state_q == ST_CORR) begin
      res1_q <= sat16(d_tm);
      if (full_q || meas_q == SEL_BRIDGE)
        res0_q <= sat16(sum);
      else if (meas_q == SEL_TEMP)
        res0_q <= sat16(d_tm);
      else
        res0_q <= raw_off_q;
    end
  end

  // --------------------------------------------------------------
  // result words
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 16'h0000;
    end else if (clk_en) begin
      rsp_valid_q <= (state_q == ST_REPORT);
      if (state_q == ST_REPORT)
        rsp_data_q <= word_q ? res1_q : res0_q;
    end
  end
endmodule : bms_device

// file: core/bms_host.sv
// host controller end of the sequencer link
`timescale 1ns/1ns
`include "bms_defines.svh"
module bms_host import bms_pkg::*; #(
  parameter int STA1_CYC = int'(`BMS_T_STA1_MS * 1000.0 * `BMS_CLK_MHZ),
  parameter int WUP1_CYC = int'(`BMS_T_WUP1_MS * 1000.0 * `BMS_CLK_MHZ),
  parameter int PROG_CYC = `BMS_T_PROG_MAX_US * `BMS_CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  bms_link_if.hst          link,
  input  wire logic        req_valid,
  input  bms_cmd_t         req_cmd,
  input  wire logic [2:0]  req_addr,
  input  wire logic [15:0] req_data,
  output logic             req_ready,
  output logic             resp_valid,
  output logic [15:0]      resp_data
);
  localparam int GAP_CYC =
    (`BMS_CLK_MHZ + `BMS_LINK_MAX_MHZ - 1) / `BMS_LINK_MAX_MHZ;

  bms_hstate_t state_q;
  logic        valid_q, wake_q, load_q, tmr_done;
  bms_cmd_t    code_q;
  logic [2:0]  addr_q;
  logic [15:0] data_q, tmr_val_q;

  assign link.cmd_valid = valid_q;
  assign link.cmd_code  = code_q;
  assign link.cmd_addr  = addr_q;
  assign link.cmd_data  = data_q;
  assign link.host_wake = wake_q;
  assign req_ready = (state_q == H_IDLE)
                   && (link.dev_ready || req_cmd == CMD_WAKE);

  bms_timer #(.W(16)) u_tmr (
    .clk    (clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .load   (load_q),
    .value  (tmr_val_q),
    .busy   (),
    .done   (tmr_done)
  );

  // --------------------------------------------------------------
  // request sequencing
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q   <= H_BOOT;
      valid_q   <= 1'b0;
      wake_q    <= 1'b0;
      load_q    <= 1'b1;
      tmr_val_q <= 16'(STA1_CYC);
      code_q    <= CMD_NOP;
      addr_q    <= 3'h0;
      data_q    <= 16'h0000;
    end else if (clk_en) begin
      load_q <= 1'b0;
      wake_q <= 1'b0;
      unique case (state_q)
        H_BOOT: if (tmr_done) state_q <= H_IDLE;
        H_IDLE: if (req_valid && req_ready) begin
          if (req_cmd == CMD_WAKE) begin
            wake_q    <= 1'b1;
            load_q    <= 1'b1;
            tmr_val_q <= 16'(WUP1_CYC);
            state_q   <= H_HOLD;
          end else begin
            valid_q <= 1'b1;
            code_q  <= req_cmd;
            addr_q  <= req_addr;
            data_q  <= req_data;
            state_q <= H_SEND;
          end
        end
        H_SEND: if (link.cmd_ack) begin
          valid_q <= 1'b0;
          load_q  <= 1'b1;
          tmr_val_q <= (code_q == CMD_NV_WRITE) ? 16'(PROG_CYC)
                                                : 16'(GAP_CYC);
          state_q <= H_HOLD;
        end
        H_HOLD: if (tmr_done) state_q <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid <= 1'b0;
      resp_data  <= 16'h0000;
    end else if (clk_en) begin
      resp_valid <= link.rsp_valid;
      if (link.rsp_valid) resp_data <= link.rsp_data;
    end
  end
endmodule : bms_host

// file: verif/bms_chk.sv
// link checker for the bridge measurement sequencer
`timescale 1ns/1ns
module bms_chk import bms_pkg::*; #(
  parameter int STA1_CYC = 20
) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        cmd_valid,
  input bms_cmd_t         cmd_code,
  input wire logic [2:0]  cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic        cmd_ack,
  input wire logic        host_wake,
  input wire logic        dev_ready,
  input wire logic        dev_busy,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data
);
  // --------------------------------
  // cycles since reset
  // --------------------------------
  logic [7:0] cyc_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cyc_q <= 8'h00;
    end else if (cyc_q != 8'hFF) begin
      cyc_q <= cyc_q + 8'h01;
    end
  end
  // --------------------------------
  // link properties
  // --------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_ack_when_idle: assert property (
    cmd_ack |-> cmd_valid && !dev_busy) else $error("ack while busy");
  chk_cmd_held: assert property (
    cmd_valid && !cmd_ack |=> cmd_valid && $stable(cmd_code)
      && $stable(cmd_addr) && $stable(cmd_data)) else $error("cmd moved");
  chk_read_reply: assert property (
    cmd_ack && cmd_code == CMD_NV_READ |=> dev_busy && !rsp_valid
      ##1 rsp_valid) else $error("read reply late");
  chk_bad_addr_zero: assert property (
    cmd_ack && cmd_code == CMD_NV_READ && cmd_addr > 3'h4
      |-> ##2 rsp_data == 16'h0000) else $error("bad read not zero");
  chk_prog_hold: assert property (
    cmd_ack && cmd_code == CMD_NV_WRITE && cmd_addr < 3'h5
      |=> dev_busy[*8] ##[1:30] !dev_busy) else $error("prog time");
  chk_boot_quiet: assert property (
    cyc_q < STA1_CYC - 1 |-> !dev_ready) else $error("ready too early");
  chk_sleep_drop: assert property (
    cmd_ack && cmd_code == CMD_SLEEP |-> ##[1:3] !dev_ready)
    else $error("still ready");
  chk_wake_delay: assert property (
    host_wake && !dev_ready |=> !dev_ready[*8] ##[1:20] dev_ready)
    else $error("wake timing");
  cov_full: cover property (cmd_ack && cmd_code == CMD_MEAS_FULL);
  cov_two_words: cover property (rsp_valid ##1 rsp_valid);
  cov_wake: cover property (host_wake);
endmodule : bms_chk

// file: verif/bms_tb_top.sv
// self-checking bench: host and device joined by the link
`timescale 1ns/1ns
`define BMS_CHK(g, e) check(32'(g), 32'(e))
module bms_tb_top import bms_pkg::*;;
  logic        clk, arst_n, req_valid, req_ready, resp_valid;
  bms_cmd_t    req_cmd;
  logic [2:0]  req_addr;
  logic [15:0] req_data, resp_data, adc_result, setup_w;
  logic        wake_tick, supply_ok, afe_autozero, afe_converting, clk_en;
  bms_sel_t    afe_sel;
  logic        afe_chop_inv, sleeping, analog_ready, log_on;
  logic [5:0]  afe_gain1;
  logic [4:0]  afe_gain2_x10, afe_msb_bits;
  logic [2:0]  afe_lsb_bits, last_ph;
  logic [2:0]  seq [$];
  int          fail_count, comparisons;
  localparam logic [5:0] G1_TAB [4] = '{6'h0C, 6'h14, 6'h1E, 6'h28};
  localparam logic [2:0] LB_TAB [4] = '{3'h0, 3'h2, 3'h4, 3'h7};
  localparam logic [2:0] PH_TAB [5] = '{3'h4, 3'h0, 3'h5, 3'h1, 3'h2};
  localparam int T_STA1 = 20, T_STA2 = 40, T_WUP1 = 10, T_WUP2 = 30;
  localparam int T_PROG_D = 16, T_PROG_H = 20, T_ADC = 1;
  // --------------------------------
  // both ends and the checker
  // --------------------------------
  bms_link_if bms_link_if_inst ();
  bms_device #(.STA1_CYC(T_STA1), .STA2_CYC(T_STA2), .WUP1_CYC(T_WUP1),
    .WUP2_CYC(T_WUP2), .PROG_CYC(T_PROG_D), .ADC_DIV(T_ADC))
    bms_device_inst (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .supply_ok(supply_ok),
    .wake_tick(wake_tick), .link(bms_link_if_inst), .afe_sel(afe_sel),
    .afe_autozero(afe_autozero), .afe_converting(afe_converting),
    .afe_chop_inv(afe_chop_inv), .afe_gain1(afe_gain1),
    .afe_gain2_x10(afe_gain2_x10), .afe_msb_bits(afe_msb_bits),
    .afe_lsb_bits(afe_lsb_bits), .adc_result(adc_result),
    .sleeping(sleeping), .analog_ready(analog_ready));
  bms_host #(.STA1_CYC(T_STA1), .WUP1_CYC(T_WUP1), .PROG_CYC(T_PROG_H))
    bms_host_inst (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .link(bms_link_if_inst),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_data(resp_data));
  bms_chk #(.STA1_CYC(T_STA1)) bms_chk_inst (.clk(clk), .arst_n(arst_n),
    .cmd_valid(bms_link_if_inst.cmd_valid),
    .cmd_code(bms_link_if_inst.cmd_code),
    .cmd_addr(bms_link_if_inst.cmd_addr),
    .cmd_data(bms_link_if_inst.cmd_data),
    .cmd_ack(bms_link_if_inst.cmd_ack),
    .host_wake(bms_link_if_inst.host_wake),
    .dev_ready(bms_link_if_inst.dev_ready),
    .dev_busy(bms_link_if_inst.dev_busy),
    .rsp_valid(bms_link_if_inst.rsp_valid),
    .rsp_data(bms_link_if_inst.rsp_data));
  // --------------------------------
  // tasks
  // --------------------------------
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : check
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  function automatic logic pick(input int k);
    logic [4:0] v;
    v = {analog_ready, sleeping, afe_converting, resp_valid, req_ready};
    return v[k];
  endfunction : pick
  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pick(k) !== 1'b1 && n < 30000);
    if (pick(k) !== 1'b1) begin
      fail_count++;
      test_done();
    end
  endtask : wait_hi
  task automatic send(input bms_cmd_t c, input logic [2:0] a,
                      input logic [15:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    req_data <= d;
    wait_hi(0);
    req_valid <= 1'b0;
  endtask : send
  task automatic read_nv(input logic [2:0] a, input logic [15:0] e);
    send(CMD_NV_READ, a, 16'h0000);
    wait_hi(1);
    `BMS_CHK(resp_data, e);
  endtask : read_nv
  // --------------------------------
  // clock, phase log, main sequence
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // auto-zero and conversion phases see different levels
  always @(posedge clk) adc_result <= afe_autozero ? 16'h1000 : 16'h1400;
  always @(posedge clk) begin
    if (log_on && afe_converting && {afe_autozero, afe_sel} !== last_ph) begin
      seq.push_back({afe_autozero, afe_sel});
      last_ph = {afe_autozero, afe_sel};
    end
  end
  initial begin
    arst_n = 1'b0;
    {req_valid, wake_tick, log_on, req_addr} = '0;
    {req_data, fail_count, comparisons} = '0;
    req_cmd = CMD_NOP;
    supply_ok = 1'b1;
    clk_en = 1'b1;
    last_ph = 3'h7;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    read_nv(3'h1, 16'h8000);
    read_nv(3'h5, 16'h0000);
    send(CMD_NV_WRITE, 3'h1, 16'hA5C3);
    read_nv(3'h1, 16'hA5C3);
    $display("test nv done");
    for (int i = 0; i < 8; i++) begin
      setup_w = {4'h0, i[0], 1'b0, i[1:0], (i == 7) ? 2'h1 : 2'h0,
                 1'b0, i[2:0], i[1:0]};
      send(CMD_NV_WRITE, 3'h0, setup_w);
      send(CMD_MEAS_BR, 3'h0, 16'h0000);
      for (int k = 0; k < 2; k++) begin
        wait_hi(k == 0 ? 2 : 1);
        `BMS_CHK(afe_gain1, G1_TAB[i[1:0]]);
        `BMS_CHK(afe_gain2_x10, 11 + i);
        `BMS_CHK(afe_lsb_bits, LB_TAB[i[1:0]]);
        `BMS_CHK(afe_msb_bits, (i == 7) ? 12 : 10);
        `BMS_CHK(afe_chop_inv, i[0]);
      end
    end
    $display("test gain done");
    log_on = 1'b1;
    send(CMD_MEAS_FULL, 3'h0, 16'h0000);
    wait_hi(1);
    `BMS_CHK(resp_data, 16'h052E);
    @(posedge clk);
    `BMS_CHK(resp_valid, 1'b1);
    `BMS_CHK(resp_data, 16'h0400);
    `BMS_CHK(seq.size(), 5);
    foreach (PH_TAB[j]) `BMS_CHK(seq[j], PH_TAB[j]);
    $display("test full done");
    supply_ok <= 1'b0;
    @(posedge clk);
    supply_ok <= 1'b1;
    @(posedge clk);
    `BMS_CHK(bms_link_if_inst.dev_ready, 1'b0);
    send(CMD_SLEEP, 3'h0, 16'h0000);
    wait_hi(3);
    `BMS_CHK(bms_link_if_inst.dev_ready, 1'b0);
    send(CMD_WAKE, 3'h0, 16'h0000);
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (12) @(posedge clk);
    `BMS_CHK(bms_link_if_inst.dev_ready, 1'b0);
    clk_en <= 1'b1;
    wait_hi(4);
    `BMS_CHK(sleeping, 1'b0);
    $display("test wake done");
    send(CMD_MODE_AUTO, 3'h0, 16'h0000);
    wait_hi(3);
    wake_tick <= 1'b1;
    @(posedge clk);
    wake_tick <= 1'b0;
    wait_hi(1);
    `BMS_CHK(resp_data, 16'h052E);
    @(posedge clk);
    `BMS_CHK(resp_valid, 1'b1);
    wait_hi(3);
    `BMS_CHK(bms_link_if_inst.dev_ready, 1'b0);
    $display("test auto done");
    test_done();
  end
endmodule : bms_tb_top
